//--- src/pdss_map.svh
// constants of the presence-detect serial slave
`ifndef PDSS_MAP_SVH
`define PDSS_MAP_SVH
`define PDSS_TYPE_MEM 4'hA
`define PDSS_TYPE_PROT 4'h6
`define PDSS_SEL_TYPE 7:4
`define PDSS_SEL_CHIP 3:1
`define PDSS_SEL_RW 0
`define PDSS_MSB 7
`define PDSS_BYTE_BITS 4'h8
`define PDSS_LAST_BIT 4'h7
`define PDSS_CLK_PERIOD_NS 8
`define PDSS_TWRC_MAX_NS 10000000
`define PDSS_FIFO_DEPTH 4
`define PDSS_DRAIN_CYC 4
`define PDSS_MEM_BYTES 256
`endif

//--- src/pdss_pkg.sv
// types of the presence-detect serial slave
package pdss_pkg;
  // bus-side progress of the slave
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_WAIT
  } pdss_state_t;
  // meaning of the byte being received
  typedef enum logic [1:0] {PH_SEL, PH_ADDR, PH_DATA} pdss_phase_t;
  // one buffered write towards the storage
  typedef struct packed {
    logic prot;
    logic [7:0] addr;
    logic [7:0] data;
  } pdss_wr_t;
endpackage

//--- src/pdss_slave.sv
// presence-detect two-wire slave with write buffer and storage
`timescale 1ns/1ps
`include "pdss_map.svh"

// ----------------------------------------
// write buffer
// ----------------------------------------
module pdss_fifo #(
  parameter int W = 17,
  parameter int D = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_q [D]; // entries
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d; // pointers
  logic [AW:0] cnt_q, cnt_d; // fill level
  logic push, pop;

  // wrap a pointer at the depth
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (cnt_q != (AW + 1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next pointers and level
  always_comb begin
    wp_d = push ? bump(wp_q) : wp_q;
    rp_d = pop ? bump(rp_q) : rp_q;
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // register pointers; entries need no reset
  always_ff @(posedge clock) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      if (push) begin
        mem_q[wp_q] <= in_data;
      end
    end
  end
endmodule

// ----------------------------------------
// serial slave
// ----------------------------------------
// Summary of operation
// - sda changes only while scl low
// - sda edge at scl high is start/stop
// - ignore everything until a start
// - stop sends slave to standby
// - transmitter releases sda after eight bits
// - receiver pulls sda low on ninth clock
// - acknowledge own select after start
// - acknowledge every written byte
// - send eight bits, then sample master ack
// - master ack continues with next byte
// - no master ack: stop, await stop
// - all bytes most significant bit first
// - select holds type, strap bits, direction
// - ignore select during write cycle time
module pdss_slave #(
  parameter int MEM_BYTES = `PDSS_MEM_BYTES,
  parameter int FIFO_DEPTH = `PDSS_FIFO_DEPTH,
  parameter int DRAIN_CYC = `PDSS_DRAIN_CYC,
  parameter int WRC_CYC = `PDSS_TWRC_MAX_NS / `PDSS_CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic strap_addr_bit0,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit2,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  output logic prog_busy
);
  localparam int AW = $clog2(MEM_BYTES);
  localparam int BW = $clog2(WRC_CYC + 1);
  localparam int DW = $clog2(DRAIN_CYC + 1);
  localparam int FW = $bits(pdss_pkg::pdss_wr_t);

  // ----------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------
  logic [1:0] scl_sy_q, sda_sy_q; // two-flop stages
  logic [2:0] strap_m_q, strap_s_q; // strap stages
  logic scl_p_q, sda_p_q; // previous settled levels
  logic scl_s, sda_s;
  logic scl_rise, scl_fall, start_w, stop_w;

  // only the second stage feeds any logic
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      strap_m_q <= 3'h0;
      strap_s_q <= 3'h0;
    end else if (ce) begin
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_sy_q <= {sda_sy_q[0], sda_i};
      scl_p_q <= scl_sy_q[1];
      sda_p_q <= sda_sy_q[1];
      strap_m_q <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
      strap_s_q <= strap_m_q;
    end
  end

  assign scl_s = scl_sy_q[1];
  assign sda_s = sda_sy_q[1];
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  // sda edges with scl high steady are never data
  assign start_w = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_w = scl_s && scl_p_q && !sda_p_q && sda_s;

  // ----------------------------------------
  // storage and buffered programming
  // ----------------------------------------
  logic [7:0] mem_q [MEM_BYTES]; // memory array
  logic [7:0] prot_reg_q; // protection byte
  logic [DW-1:0] drain_q, drain_d; // pacing of writes
  logic f_in_ready, f_out_valid, f_out_ready, push;
  pdss_pkg::pdss_wr_t f_in, f_out;

  pdss_fifo #(.W(FW), .D(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(f_in),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out)
  );

  // one write every DRAIN_CYC cycles; a full buffer stretches scl
  assign f_out_ready = (drain_q == '0);
  always_comb begin
    drain_d = drain_q;
    if (f_out_valid && f_out_ready) begin
      drain_d = DW'(DRAIN_CYC - 1);
    end else if (drain_q != '0) begin
      drain_d = drain_q - 1'b1;
    end
  end

  // storage holds no reset so contents survive it
  always_ff @(posedge clock) begin
    if (rst) begin
      drain_q <= '0;
    end else if (ce) begin
      drain_q <= drain_d;
      if (f_out_valid && f_out_ready) begin
        if (!f_out.prot) begin
          mem_q[f_out.addr[AW-1:0]] <= f_out.data;
        end
      end
    end
  end

  // protection byte is control state, so it resets
  always_ff @(posedge clock) begin
    if (rst) begin
      prot_reg_q <= 8'h00;
    end else if (ce && f_out_valid && f_out_ready && f_out.prot) begin
      prot_reg_q <= f_out.data;
    end
  end

  // ----------------------------------------
  // bus state machine
  // ----------------------------------------
  pdss_pkg::pdss_state_t st_q, st_d;
  pdss_pkg::pdss_phase_t ph_q, ph_d;
  logic [3:0] cnt_q, cnt_d; // bit count
  logic [7:0] sh_q, sh_d; // shift register
  logic [AW-1:0] ptr_q, ptr_d; // byte pointer
  logic rw_q, rw_d, prot_q, prot_d; // direction, target
  logic mack_q, mack_d; // master acknowledged
  logic wr_q, wr_d; // data written this transfer
  logic [BW-1:0] busy_q, busy_d; // write cycle timer
  logic sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
  logic sda_o_q, scl_o_q, busy_out_q;
  logic byte_end, sel_hit;
  logic [7:0] rd_byte;

  // a select matches type code and straps; sel_hit also needs busy_q at zero, so not while programming
  function automatic logic sel_match(input logic [7:0] b, input logic [2:0] s);
    sel_match = (b[`PDSS_SEL_TYPE] == `PDSS_TYPE_MEM ||
                 b[`PDSS_SEL_TYPE] == `PDSS_TYPE_PROT) && b[`PDSS_SEL_CHIP] == s;
  endfunction

  // byte complete, held while scl is stretched
  assign byte_end = (cnt_q == `PDSS_BYTE_BITS) && (scl_fall || scl_oe_q);
  assign sel_hit = sel_match(sh_q, strap_s_q) && (busy_q == '0);
  // reads do not see bytes still in the buffer
  assign rd_byte = prot_q ? prot_reg_q : mem_q[ptr_q];
  assign f_in = '{prot: prot_q, addr: 8'(ptr_q), data: sh_q};

  // next state of the bus side
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    prot_d = prot_q;
    mack_d = mack_q;
    wr_d = wr_q;
    sda_oe_d = sda_oe_q;
    scl_oe_d = 1'b0;
    push = 1'b0;
    busy_d = (busy_q != '0) ? busy_q - 1'b1 : busy_q;
    if (start_w) begin
      st_d = pdss_pkg::ST_RX;
      ph_d = pdss_pkg::PH_SEL;
      cnt_d = 4'h0;
      sda_oe_d = 1'b0;
    end else if (stop_w) begin
      st_d = pdss_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
      wr_d = 1'b0;
      if (wr_q) begin
        busy_d = BW'(WRC_CYC);
      end
    end else begin
      unique case (st_q)
        pdss_pkg::ST_IDLE, pdss_pkg::ST_WAIT: begin
          // deaf until the next start
        end
        pdss_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 1'b1;
          end else if (byte_end) begin
            unique case (ph_q)
              pdss_pkg::PH_SEL: begin
                if (sel_hit) begin
                  sda_oe_d = 1'b1;
                  st_d = pdss_pkg::ST_ACK;
                  rw_d = sh_q[`PDSS_SEL_RW];
                  prot_d = (sh_q[`PDSS_SEL_TYPE] == `PDSS_TYPE_PROT);
                end else begin
                  st_d = pdss_pkg::ST_WAIT;
                end
              end
              pdss_pkg::PH_ADDR: begin
                ptr_d = sh_q[AW-1:0];
                sda_oe_d = 1'b1;
                st_d = pdss_pkg::ST_ACK;
              end
              pdss_pkg::PH_DATA: begin
                if (!f_in_ready) begin
                  scl_oe_d = 1'b1; // hold scl low until room
                end else begin
                  push = 1'b1;
                  ptr_d = ptr_q + 1'b1;
                  wr_d = 1'b1;
                  sda_oe_d = 1'b1;
                  // after a stretch, keep scl low one more cycle so sda settles first
                  scl_oe_d = scl_oe_q;
                  st_d = pdss_pkg::ST_ACK;
                end
              end
              default: st_d = pdss_pkg::ST_WAIT;
            endcase
          end
        end
        pdss_pkg::ST_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            cnt_d = 4'h0;
            if (ph_q == pdss_pkg::PH_SEL && rw_q) begin
              sh_d = rd_byte;
              sda_oe_d = !rd_byte[`PDSS_MSB];
              ptr_d = ptr_q + 1'b1;
              st_d = pdss_pkg::ST_TX;
            end else begin
              st_d = pdss_pkg::ST_RX;
              ph_d = (ph_q == pdss_pkg::PH_SEL) ? pdss_pkg::PH_ADDR : pdss_pkg::PH_DATA;
            end
          end
        end
        pdss_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == `PDSS_LAST_BIT) begin
              sda_oe_d = 1'b0;
              st_d = pdss_pkg::ST_TXACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              sda_oe_d = !sh_q[6];
              cnt_d = cnt_q + 1'b1;
            end
          end
        end
        pdss_pkg::ST_TXACK: begin
          if (scl_rise) begin
            mack_d = !sda_s;
          end else if (scl_fall) begin
            cnt_d = 4'h0;
            if (mack_q) begin
              sh_d = rd_byte;
              sda_oe_d = !rd_byte[`PDSS_MSB];
              ptr_d = ptr_q + 1'b1;
              st_d = pdss_pkg::ST_TX;
            end else begin
              st_d = pdss_pkg::ST_WAIT;
            end
          end
        end
      endcase
    end
  end

  // register the bus side; pin drivers are plain flops
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= pdss_pkg::ST_IDLE;
      ph_q <= pdss_pkg::PH_SEL;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= '0;
      rw_q <= 1'b0;
      prot_q <= 1'b0;
      mack_q <= 1'b0;
      wr_q <= 1'b0;
      busy_q <= '0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_o_q <= 1'b0;
      scl_o_q <= 1'b0;
      busy_out_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      prot_q <= prot_d;
      mack_q <= mack_d;
      wr_q <= wr_d;
      busy_q <= busy_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
      sda_o_q <= 1'b0;
      scl_o_q <= 1'b0;
      busy_out_q <= (busy_d != '0);
    end
  end

  assign sda_oe = sda_oe_q;
  assign scl_oe = scl_oe_q;
  assign sda_o = sda_o_q;
  assign scl_o = scl_o_q;
  assign prog_busy = busy_out_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_sel_end;
    st_q == pdss_pkg::ST_RX && ph_q == pdss_pkg::PH_SEL && byte_end && ce;
  endsequence
  sequence s_quiet;
    !start_w && !stop_w && ce;
  endsequence

  chk_sda_scl_low: assert property (
    $changed(sda_oe_q) && !$past(start_w) && !$past(stop_w) |-> !$past(scl_s))
    else $error("sda moved while scl high");
  chk_start_rx: assert property (start_w && ce |=> st_q == pdss_pkg::ST_RX && cnt_q == 4'h0)
    else $error("start not taken");
  chk_idle_deaf: assert property (
    st_q == pdss_pkg::ST_IDLE && !start_w |=> st_q == pdss_pkg::ST_IDLE && !sda_oe_q)
    else $error("idle slave reacted");
  chk_stop_idle: assert property (stop_w && ce |=> st_q == pdss_pkg::ST_IDLE)
    else $error("stop ignored");
  chk_sel_ack: assert property (
    s_sel_end and s_quiet and sel_hit |=> sda_oe_q && st_q == pdss_pkg::ST_ACK)
    else $error("own select not acknowledged");
  chk_busy_deaf: assert property (
    s_sel_end and s_quiet and busy_q != '0 |=> st_q == pdss_pkg::ST_WAIT && !sda_oe_q)
    else $error("select answered while programming");
  chk_write_ack: assert property (
    st_q == pdss_pkg::ST_RX && ph_q == pdss_pkg::PH_DATA && byte_end && f_in_ready
    ##0 s_quiet |=> sda_oe_q && ptr_q == $past(ptr_q) + 1'b1)
    else $error("write byte not acknowledged");
  chk_tx_release: assert property (st_q == pdss_pkg::ST_TXACK |-> !sda_oe_q)
    else $error("sda held in master ack slot");
  chk_nack_wait: assert property (
    st_q == pdss_pkg::ST_TXACK && scl_fall && !mack_q ##0 s_quiet
    |=> st_q == pdss_pkg::ST_WAIT [*2])
    else $error("sending after missing ack");
endmodule

//--- verif/pdss_host.sv
// host two-wire master model facing the presence-detect slave
`timescale 1ns/1ps

// ----------------------------------------
// bus master model
// ----------------------------------------
module pdss_host (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_m,
  output logic sda_m
);
  localparam realtime Q = 31.25; // quarter of the 125 ns link period
  // idle bus: both lines released, link clock stands still
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // release scl, then sit out any stretch by the slave
  task automatic scl_up();
    int n;
    scl_m = 1'b1;
    n = 0;
    while (scl_w !== 1'b1 && n < 20000) begin
      #1;
      n++;
    end
  endtask
  // pull scl low from idle without forming a start
  task automatic hold_low();
    #Q;
    scl_m = 1'b0;
  endtask
  // sda falls while scl stands high
  task automatic start();
    #Q;
    sda_m = 1'b1;
    #Q;
    scl_up();
    #Q;
    sda_m = 1'b0;
    #Q;
    scl_m = 1'b0;
  endtask
  // sda rises while scl stands high; bus left idle
  task automatic stop();
    #Q;
    sda_m = 1'b0;
    #Q;
    scl_up();
    #Q;
    sda_m = 1'b1;
    #Q;
  endtask
  // one clock; data moves mid-low, sampled mid-high; starts and ends with scl low
  task automatic clk_bit(input logic b, output logic s);
    #Q;
    sda_m = b;
    #Q;
    scl_up();
    #Q;
    s = sda_w;
    #Q;
    scl_m = 1'b0;
  endtask
  // n bits msb first, then the ninth clock once the byte is whole
  task automatic xfer(input logic [7:0] d, input int n, input logic m_ack,
                      output logic [7:0] r, output logic ack);
    r = 8'hFF;
    ack = 1'b1;
    for (int i = 0; i < n; i++) clk_bit(d[7-i], r[7-i]);
    if (n == 8) clk_bit(m_ack, ack);
  endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench of the presence-detect serial slave
`timescale 1ns/1ps
`include "pdss_map.svh"

// ----------------------------------------
// bench top
// ----------------------------------------
module tb_top;
  localparam int WRC = 200; // shortened write cycle, keeps the run brief
  localparam int DRN = 300; // slow buffer drain, so a long page write fills it
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] strap = 3'h0; // strap pin levels
  int seed = 32'h8B2A86D9;
  int bad_count = 0;
  int checks = 0;
  int hi_cnt = 0; // cycles scl has stood high
  int busy_len = 0; // cycles of write-cycle busy seen
  logic oe_q = 1'b0;
  logic scl_w, sda_w, scl_m, sda_m, scl_o, scl_oe, sda_o, sda_oe, prog_busy;
  logic [7:0] exp_mem [256]; // bytes written by the bench
  logic [7:0] r, a0, d, ix;
  logic [3:0] t;
  logic [2:0] s;
  logic ack;
  int stretch = 0; // cycles the slave held scl low

  always #4 clock = ~clock;
  // open-drain wires with pull-ups
  assign scl_w = scl_m & (scl_oe ? scl_o : 1'b1);
  assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);

  pdss_slave #(.DRAIN_CYC(DRN), .WRC_CYC(WRC)) pdss_slave_inst (
    .clock(clock), .rst(rst), .ce(1'b1), .scl_i(scl_w), .sda_i(sda_w),
    .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
    .strap_addr_bit2(strap[2]), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_o(sda_o), .sda_oe(sda_oe), .prog_busy(prog_busy));
  pdss_host pdss_host_inst (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));

  // single comparison, counted
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic wrap_up();
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // only a known type with matching straps is acknowledged
  function automatic logic exp_ack(input logic [3:0] ty, input logic [2:0] st);
    return !((ty == `PDSS_TYPE_MEM || ty == `PDSS_TYPE_PROT) && st == strap);
  endfunction
  // select byte: type, straps, direction
  task automatic sel(input logic [3:0] ty, input logic [2:0] st, input logic rw,
                     output logic a);
    logic [7:0] rr;
    pdss_host_inst.xfer({ty, st, rw}, 8, 1'b1, rr, a);
  endtask
  // bounded wait for the write cycle to end
  task automatic wait_idle();
    int n;
    n = 0;
    while (prog_busy !== 1'b0 && n < 4 * WRC) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask

  // slave may move sda only while scl is low; busy length counted
  always @(posedge clock) begin
    hi_cnt <= (scl_w === 1'b1) ? hi_cnt + 1 : 0;
    oe_q <= sda_oe;
    if (prog_busy === 1'b1) busy_len <= busy_len + 1;
    if (scl_oe === 1'b1) stretch <= stretch + 1;
    if (!rst && hi_cnt > 4) chk(sda_oe, oe_q);
  end

  // watchdog, far beyond the expected run
  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end

  initial begin
    strap = 3'($random(seed));
    repeat (8) @(posedge clock);
    #1;
    rst = 1'b0;
    // all pin drivers quiet out of reset
    @(posedge clock);
    #1;
    chk({scl_o, scl_oe, sda_o, sda_oe, prog_busy}, 17'h0);
    // a valid select without a start is ignored
    pdss_host_inst.hold_low();
    pdss_host_inst.xfer({`PDSS_TYPE_MEM, strap, 1'b0}, 8, 1'b1, r, ack);
    chk(ack, 1'b1);
    // protection byte holds its reset value
    pdss_host_inst.start();
    sel(`PDSS_TYPE_PROT, strap, 1'b1, ack);
    chk(ack, 1'b0);
    pdss_host_inst.xfer(8'hFF, 8, 1'b1, r, ack);
    chk(r, 8'h00);
    pdss_host_inst.stop();
    // every type code, then a strap mismatch
    for (int i = 0; i < 17; i++) begin
      t = (i == 16) ? `PDSS_TYPE_MEM : 4'(i);
      s = (i == 16) ? ~strap : strap;
      pdss_host_inst.start();
      sel(t, s, 1'b0, ack);
      chk(ack, exp_ack(t, s));
      pdss_host_inst.stop();
    end
    // page write long enough to fill the slow buffer, then a cut byte
    a0 = 8'($random(seed));
    pdss_host_inst.start();
    sel(`PDSS_TYPE_MEM, strap, 1'b0, ack);
    pdss_host_inst.xfer(a0, 8, 1'b1, r, ack);
    chk(ack, 1'b0);
    for (int i = 0; i < 10; i++) begin
      d = 8'($random(seed));
      ix = a0 + 8'(i);
      exp_mem[ix] = d;
      pdss_host_inst.xfer(d, 8, 1'b1, r, ack);
      chk(ack, 1'b0);
    end
    pdss_host_inst.xfer(8'h5A, 3, 1'b1, r, ack);
    pdss_host_inst.stop();
    chk(stretch != 0, 1'b1);
    repeat (10) @(posedge clock);
    #1;
    chk(prog_busy, 1'b1);
    // deaf to its own select while programming
    pdss_host_inst.start();
    sel(`PDSS_TYPE_MEM, strap, 1'b0, ack);
    chk(ack, 1'b1);
    pdss_host_inst.stop();
    wait_idle();
    chk(busy_len, WRC);
    chk(prog_busy, 1'b0);
    // let the slow buffer empty before reading back
    repeat (4 * DRN) @(posedge clock);
    #1;
    chk(scl_oe, 1'b0);
    // random address read: ten bytes, the last refused
    pdss_host_inst.start();
    sel(`PDSS_TYPE_MEM, strap, 1'b0, ack);
    pdss_host_inst.xfer(a0, 8, 1'b1, r, ack);
    pdss_host_inst.start();
    sel(`PDSS_TYPE_MEM, strap, 1'b1, ack);
    chk(ack, 1'b0);
    for (int i = 0; i < 10; i++) begin
      ix = a0 + 8'(i);
      pdss_host_inst.xfer(8'hFF, 8, i == 9, r, ack);
      chk(r, exp_mem[ix]);
    end
    // after the refusal the slave leaves sda alone
    pdss_host_inst.xfer(8'hFF, 8, 1'b1, r, ack);
    chk(r, 8'hFF);
    pdss_host_inst.stop();
    // standby after the stop: bits without a start are ignored
    pdss_host_inst.hold_low();
    pdss_host_inst.xfer({`PDSS_TYPE_MEM, strap, 1'b0}, 8, 1'b1, r, ack);
    chk(ack, 1'b1);
    // protection byte write and read back
    d = 8'($random(seed));
    pdss_host_inst.start();
    sel(`PDSS_TYPE_PROT, strap, 1'b0, ack);
    pdss_host_inst.xfer(8'h00, 8, 1'b1, r, ack);
    pdss_host_inst.xfer(d, 8, 1'b1, r, ack);
    chk(ack, 1'b0);
    pdss_host_inst.stop();
    repeat (10) @(posedge clock);
    wait_idle();
    pdss_host_inst.start();
    sel(`PDSS_TYPE_PROT, strap, 1'b1, ack);
    pdss_host_inst.xfer(8'hFF, 8, 1'b1, r, ack);
    chk(r, d);
    pdss_host_inst.stop();
    wrap_up();
  end
endmodule
